// [pkg/smc_pkg.sv]
// Package for the sleep mode clock gating controller.
package smc_pkg;
  localparam logic [2:0] MODE_IDLE = 3'h0;
  localparam logic [2:0] MODE_QUIET = 3'h1;
  localparam logic [2:0] MODE_PDOWN = 3'h2;
  localparam logic [2:0] MODE_PSAVE = 3'h3;
  localparam logic [2:0] MODE_RSV4 = 3'h4;
  localparam logic [2:0] MODE_RSV5 = 3'h5;
  localparam logic [2:0] MODE_STBY = 3'h6;
  localparam logic [2:0] MODE_XSTBY = 3'h7;
  localparam int STBY_WAKE_CYC = 6;
  localparam int IRQ_STALL_CYC = 4;
  localparam int STARTUP_DEF = 16;
  localparam int CNT_W = 16;

  typedef enum logic [2:0] {
    SMC_RUN = 3'h0,
    SMC_SLEEP = 3'h1,
    SMC_WAKE = 3'h3,
    SMC_STALL = 3'h2
  } smc_state_e;

  // One bit per clock domain or oscillator that the controller can stop.
  typedef struct packed {
    logic core_clk;
    logic flash_clk;
    logic periph_clk;
    logic conv_clk;
    logic async_clk;
    logic usb_clk;
    logic main_osc;
    logic timer_osc;
    logic pll;
  } smc_clk_en_s;

  // Wake sources, each already qualified by its own interrupt enable.
  typedef struct packed {
    logic upper_ext_level;
    logic upper_ext_edge;
    logic lower_ext;
    logic pin_change;
    logic twi_match;
    logic twi_irq;
    logic timer2_irq;
    logic spm_ready;
    logic conv_done;
    logic wdt_irq;
    logic comparator;
    logic other_io;
    logic usb_sync;
    logic usb_async;
  } smc_wake_s;
endpackage

// [hw/smc_counter.sv]
// Down counter that times wake-up and stall delays.
module smc_counter
  import smc_pkg::*;
#(
  parameter int W = CNT_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [W-1:0] value_i,
  output logic done_o
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic busy_q;

  if (W < 3)
  begin : g_bad_width
    $error("smc_counter width too small");
  end

  assign cnt_d = load_i ? value_i : (cnt_q - W'(1));
  assign done_o = busy_q && (cnt_q == W'(1));

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= '0;
      busy_q <= 1'b0;
    end
    else if (load_i || busy_q)
    begin
      cnt_q <= cnt_d;
      busy_q <= load_i || (cnt_q > W'(1));
    end
  end
endmodule // smc_counter

// [hw/smc_ctrl.sv]
// Sleep mode controller: mode entry, clock gating and wake-up timing.
//
// Contract
// - Mode 000 with sleep enters idle: core and flash clocks stop.
// - Idle wakes on any enabled external or internal interrupt.
// - Entering idle or quiet mode starts a conversion if converter enabled.
// - Mode 001 enters quiet mode: peripheral, core, flash clocks stop.
// - Quiet mode wakes only on its listed converter-friendly sources.
// - Mode 010 enters power-down: oscillator and all generated clocks stop.
// - Power-down wakes only on resets, watchdog, match, lines, pin change, USB async.
// - Leaving power-down waits a fuse-chosen start-up delay.
// - Mode 011 enters power-save: power-down plus running timer 2 wake.
// - Power-save stops unused timer sources; sync clock reaches timer 2 only.
// - Mode 110 with crystal enters standby: oscillator runs, PLL off.
// - Mode 111 with crystal: extended standby, power-save with oscillator on.
// - Standby modes resume six main clock cycles after wake condition.
// - Comparator disable powers comparator down; its interrupt cannot wake.
// - Sleep needs enable bit at instruction; codes 100 and 101 are reserved.
// - Interrupt wake stalls four more cycles; reset during sleep restarts.
module smc_ctrl
  import smc_pkg::*;
#(
  parameter int STARTUP_CYC = STARTUP_DEF
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sleep_instr_i,
  input wire logic sleep_enable_bit_i,
  input wire logic [2:0] sleep_mode_select_i,
  input wire logic crystal_sel_i,
  input wire logic [CNT_W-1:0] clock_source_fuses_i,
  input wire logic conv_enable_i,
  input wire logic comparator_disable_bit_i,
  input wire logic timer2_enable_i,
  input wire logic timer2_async_i,
  input wire logic global_irq_en_i,
  input wire logic reset_wake_i,
  input wire smc_wake_s wake_i,
  output logic sleeping_o,
  output logic core_stall_o,
  output logic irq_service_o,
  output logic restart_vector_o,
  output logic conv_start_o,
  output logic comparator_power_o,
  output logic [2:0] active_mode_o,
  output smc_clk_en_s clk_en_o
);
  smc_state_e state_q;
  smc_state_e state_d;
  logic [2:0] mode_q;
  logic by_reset_q;
  logic conv_start_q;
  logic cnt_load;
  logic [CNT_W-1:0] cnt_val;
  logic cnt_done;
  logic enter;
  logic mode_legal;
  logic wake_any;
  logic wake_reset;
  logic wake_irq;
  logic std_mode;
  smc_clk_en_s gate;
  smc_wake_s wake_qual;
  logic gated;
  logic long_start;
  logic wake_done;
  logic stall_done;
  logic [CNT_W-1:0] start_cyc;

  // A zero count would leave the counter idle and the core asleep forever.
  if (STARTUP_CYC < 1 || STARTUP_CYC >= (1 << CNT_W))
  begin : g_bad_startup
    $error("smc_ctrl startup count out of range");
  end

  // Returns whether a qualified wake event may end sleep in a mode.
  function automatic logic wake_allowed(input logic [2:0] m,
                                        input smc_wake_s w,
                                        input logic t2_ok);
    logic deep;
    deep = w.upper_ext_level || w.lower_ext || w.pin_change ||
           w.twi_match || w.usb_async || w.wdt_irq;
    case (m)
      MODE_IDLE: wake_allowed = |w;
      MODE_QUIET: wake_allowed = w.conv_done || w.wdt_irq || w.twi_irq ||
                  w.twi_match || w.timer2_irq || w.spm_ready ||
                  w.upper_ext_level || w.lower_ext || w.pin_change ||
                  w.usb_sync || w.usb_async;
      MODE_PDOWN, MODE_STBY: wake_allowed = deep;
      MODE_PSAVE, MODE_XSTBY: wake_allowed = deep ||
                  (t2_ok && w.timer2_irq);
      default: wake_allowed = 1'b0;
    endcase
  endfunction

  // Reserved codes make the sleep instruction a no-operation.
  assign mode_legal = (sleep_mode_select_i != MODE_RSV4) &&
                      (sleep_mode_select_i != MODE_RSV5) &&
                      (crystal_sel_i || !sleep_mode_select_i[2]);
  assign enter = (state_q == SMC_RUN) && sleep_instr_i &&
                 sleep_enable_bit_i && mode_legal;

  // A powered-down comparator may leave a stale flag; it must not wake.
  always_comb
  begin
    wake_qual = wake_i;
    wake_qual.comparator = wake_i.comparator &&
                           !comparator_disable_bit_i;
  end

  assign wake_reset = reset_wake_i;
  assign wake_irq = wake_allowed(mode_q, wake_qual,
                                 timer2_enable_i && global_irq_en_i);
  assign wake_any = (state_q == SMC_SLEEP) && (wake_reset || wake_irq);
  assign std_mode = (mode_q == MODE_STBY) || (mode_q == MODE_XSTBY);

  assign long_start = (mode_q == MODE_PDOWN) || (mode_q == MODE_PSAVE);
  // Fuses left at zero fall back to the built-in start-up count.
  assign start_cyc = (clock_source_fuses_i == '0) ?
                     CNT_W'(STARTUP_CYC) : clock_source_fuses_i;
  assign wake_done = (state_q == SMC_WAKE) && cnt_done;
  assign stall_done = (state_q == SMC_STALL) && cnt_done;
  assign gated = (state_q == SMC_SLEEP) || (state_q == SMC_WAKE);

  // Deep modes need the oscillator restart time; standby keeps it running.
  assign cnt_val =
    (state_q == SMC_WAKE) ? CNT_W'(IRQ_STALL_CYC) :
    std_mode ? CNT_W'(STBY_WAKE_CYC) :
    long_start ? start_cyc :
    CNT_W'(1);
  // The stall is loaded as the restart ends, so the two delays add up.
  assign cnt_load = wake_any || (wake_done && !by_reset_q);

  smc_counter #(
    .W(CNT_W)
  ) u_cnt (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .load_i(cnt_load),
    .value_i(cnt_val),
    .done_o(cnt_done)
  );

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      SMC_RUN: if (enter) state_d = SMC_SLEEP;
      SMC_SLEEP: if (wake_any) state_d = SMC_WAKE;
      SMC_WAKE: if (cnt_done) state_d = by_reset_q ? SMC_RUN : SMC_STALL;
      SMC_STALL: if (cnt_done) state_d = SMC_RUN;
      default: state_d = SMC_RUN;
    endcase
  end

  // Clock gating per mode while asleep or restarting.
  always_comb
  begin
    gate = '1;
    if (gated)
    begin
      gate.core_clk = 1'b0;
      gate.flash_clk = 1'b0;
      case (mode_q)
        MODE_IDLE: gate.timer_osc = timer2_async_i;
        MODE_QUIET:
        begin
          gate.periph_clk = 1'b0;
          gate.timer_osc = timer2_async_i;
        end
        MODE_PDOWN, MODE_STBY:
        begin
          gate = '0;
          gate.main_osc = (mode_q == MODE_STBY);
        end
        default:
        begin
          gate = '0;
          gate.async_clk = timer2_enable_i && timer2_async_i;
          gate.timer_osc = timer2_enable_i && timer2_async_i;
          gate.main_osc = (mode_q == MODE_XSTBY) ||
                          (timer2_enable_i && !timer2_async_i);
        end
      endcase
    end
  end

  // The mode is latched at entry, so a later write to the select bits
  // cannot change which clocks stay stopped during sleep.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= SMC_RUN;
      mode_q <= MODE_IDLE;
      by_reset_q <= 1'b0;
      conv_start_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (enter)
        mode_q <= sleep_mode_select_i;
      if (wake_any)
        by_reset_q <= wake_reset;
      conv_start_q <= enter && conv_enable_i &&
                      (sleep_mode_select_i[2:1] == 2'h0);
    end
  end

  assign sleeping_o = (state_q == SMC_SLEEP);
  assign core_stall_o = (state_q != SMC_RUN);
  assign irq_service_o = stall_done;
  assign restart_vector_o = wake_done && by_reset_q;
  assign conv_start_o = conv_start_q;
  assign comparator_power_o = !comparator_disable_bit_i;
  assign active_mode_o = mode_q;
  assign clk_en_o = gate;
endmodule // smc_ctrl

// [tb/smc_ctrl_props.sv]
// Checker for the sleep mode controller ports.
module smc_ctrl_props
  import smc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sleep_instr_i,
  input wire logic sleep_enable_bit_i,
  input wire logic [2:0] sleep_mode_select_i,
  input wire logic conv_enable_i,
  input wire logic comparator_disable_bit_i,
  input wire logic reset_wake_i,
  input wire logic sleeping_o,
  input wire logic core_stall_o,
  input wire logic irq_service_o,
  input wire logic restart_vector_o,
  input wire logic conv_start_o,
  input wire logic comparator_power_o,
  input wire logic [2:0] active_mode_o,
  input wire smc_clk_en_s clk_en_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  wire logic go = !core_stall_o && sleep_instr_i && sleep_enable_bit_i;
  wire logic [2:0] sm = sleep_mode_select_i;
  wire logic [2:0] am = active_mode_o;
  a_idle_clocks: assert property (
    sleeping_o && am == MODE_IDLE |-> !clk_en_o.core_clk
    && !clk_en_o.flash_clk && clk_en_o.periph_clk) else $error("idle");
  a_quiet_clocks: assert property (
    sleeping_o && am == MODE_QUIET |-> !clk_en_o.periph_clk
    && clk_en_o.conv_clk && clk_en_o.usb_clk) else $error("quiet");
  a_pdown_clocks: assert property (
    sleeping_o && am == MODE_PDOWN |-> clk_en_o == '0) else $error("pdown");
  a_stby_osc: assert property (
    sleeping_o && am == MODE_STBY |-> clk_en_o.main_osc && !clk_en_o.pll
    && !clk_en_o.usb_clk) else $error("stby");
  a_xstby_osc: assert property (
    sleeping_o && am == MODE_XSTBY |-> clk_en_o.main_osc
    && !clk_en_o.core_clk) else $error("xstby");
  a_entry_taken: assert property (
    go && sm <= MODE_PSAVE |=> sleeping_o && am == $past(sm))
    else $error("entry");
  a_reserved_ignored: assert property (
    go && (sm == MODE_RSV4 || sm == MODE_RSV5) |=> !core_stall_o)
    else $error("reserved");
  a_conv_start: assert property (
    go && conv_enable_i && sm <= MODE_QUIET |=> ##[0:1] conv_start_o)
    else $error("conv");
  a_stby_wake: assert property (
    $fell(sleeping_o) && am == MODE_STBY && !$past(reset_wake_i)
    |-> ##9 irq_service_o) else $error("stby wake");
  a_irq_resume: assert property (
    irq_service_o |=> !core_stall_o) else $error("resume");
  a_comp_power: assert property (
    comparator_power_o == !comparator_disable_bit_i) else $error("comp");
  c_enter: cover property (go ##1 sleeping_o);
  c_irq: cover property (irq_service_o);
  c_restart: cover property (restart_vector_o);
endmodule // smc_ctrl_props

bind smc_ctrl smc_ctrl_props smc_ctrl_props_i (.clk_i, .rst_n_i,
  .sleep_instr_i, .sleep_enable_bit_i, .sleep_mode_select_i,
  .conv_enable_i, .comparator_disable_bit_i, .reset_wake_i, .sleeping_o,
  .core_stall_o, .irq_service_o, .restart_vector_o, .conv_start_o,
  .comparator_power_o, .active_mode_o, .clk_en_o);

// [tb/smc_core_model.sv]
// Core side model that raises and holds wake sources.
module smc_core_model
  import smc_pkg::*;
(
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [13:0] src_i,
  input wire logic sleeping_i,
  output smc_wake_s wake_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial wake_o = '0;
  // Levels stay up until sleep ends, so a slow wake path cannot miss them.
  always @(posedge clk_i)
  begin
    if (go_i)
      wake_o <= src_i;
    else if (!sleeping_i)
      wake_o <= '0;
  end
endmodule // smc_core_model

// [tb/tb_smc_ctrl.sv]
// Testbench for the sleep mode controller.
module tb_smc_ctrl
  import smc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FUS = 10;
  logic clk_i = 0, rst_n_i = 0, si = 0, en = 0, xt = 1, ce = 0, rw = 0;
  logic go = 0, cd = 1, sl, cs, irq, rv, cst, cp;
  logic [2:0] md = 3'h0, am;
  logic [13:0] src = 14'h0000;
  smc_wake_s wk;
  smc_clk_en_s ck;
  int failures = 0, n_checks = 0, convs = 0, irqs = 0, k, g, n;
  int modes[6] = '{0, 1, 2, 3, 6, 7};
  int good[6] = '{0, 32, 2048, 128, 1024, 128};
  int bad[6] = '{8, 4, 32, 64, 2, 4};
  int osc[6] = '{1, 1, 0, 0, 1, 1};
  int dly[6] = '{1, 1, FUS, FUS, 6, 6};
  int rm[4] = '{4, 5, 0, 6};
  smc_ctrl smc_ctrl_i (.clk_i, .rst_n_i, .sleep_instr_i(si),
    .sleep_enable_bit_i(en), .sleep_mode_select_i(md), .crystal_sel_i(xt),
    .clock_source_fuses_i(16'(FUS)), .conv_enable_i(ce),
    .comparator_disable_bit_i(cd), .timer2_enable_i(1'b1),
    .timer2_async_i(1'b1), .global_irq_en_i(1'b1), .reset_wake_i(rw),
    .wake_i(wk), .sleeping_o(sl), .core_stall_o(cs), .irq_service_o(irq),
    .restart_vector_o(rv), .conv_start_o(cst), .comparator_power_o(cp),
    .active_mode_o(am), .clk_en_o(ck));
  smc_core_model smc_core_model_i (.clk_i, .go_i(go), .src_i(src),
    .sleeping_i(sl), .wake_o(wk));
  initial
  begin
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    if (cst === 1'b1)
      convs++;
    if (irq === 1'b1)
      irqs++;
  end
  task automatic chk(input logic [15:0] gv, input logic [15:0] ev);
    n_checks++;
    if (gv !== ev)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, gv, ev);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic step(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask
  task automatic sleep(input int m, input logic e, input logic x);
    md = 3'(m);
    en = e;
    xt = x;
    si = 1;
    step(1);
    si = 0;
  endtask
  task automatic raise(input int s);
    src = 14'(s);
    go = 1;
    step(1);
    go = 0;
  endtask
  initial
  begin
    void'($urandom(72));
    step(5);
    rst_n_i = 1;
    step(1);
    foreach (modes[i])
    begin
      ce = (i == 0);
      sleep(modes[i], 1, 1);
      chk(sl, 16'h1);
      chk(ck.main_osc, 16'(osc[i]));
      chk(ck.periph_clk, i == 0);
      chk(am, 16'(modes[i]));
      raise(bad[i]);
      step(4);
      chk(sl, 16'h1);
      g = $urandom % 13;
      g = (i == 0) ? 1 << (g + (g >= 3)) : good[i];
      raise(g);
      n = 0;
      for (k = 0; k < 200 && cs !== 1'b0; k++)
      begin
        step(1);
        n += (sl === 1'b0 && cs === 1'b1);
      end
      chk(16'(n), 16'(dly[i] + 4));
      if (k == 200)
      begin
        failures++;
        stop_test();
      end
      $display("test mode %0d done", modes[i]);
    end
    foreach (rm[i])
    begin
      sleep(rm[i], i != 2, i != 3);
      chk(cs, 16'h0);
      step(1);
    end
    $display("test refused done");
    chk(cp, 16'h0);
    cd = 0;
    step(1);
    chk(cp, 16'h1);
    cd = 1;
    sleep(2, 1, 1);
    rw = 1;
    for (k = 0; k < 300 && rv !== 1'b1; k++)
      step(1);
    chk(rv, 16'h1);
    rw = 0;
    step(2);
    chk(cs, 16'h0);
    chk(16'(convs), 16'h1);
    chk(16'(irqs), 16'h6);
    $display("test reset wake done");
    stop_test();
  end
endmodule // tb_smc_ctrl
